/* verilog/ssc_map.vh */
`ifndef SSC_MAP_VH
`define SSC_MAP_VH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define OFS_CONTROL       5'h00
`define OFS_STATUS        5'h04
`define OFS_TX_BUFFER     5'h08
`define OFS_RX_BUFFER     5'h0C
`define OFS_BAUD          5'h10
`define OFS_GP_PORT       5'h14

// ----------------------------------------
// Control word fields
// ----------------------------------------
`define CTL_PORT_ENABLE   0
`define CTL_MASTER        1
`define CTL_PHASE         2
`define CTL_POLARITY      3
`define CTL_WIDTH_LO      4
`define CTL_WIDTH_HI      7
`define CTL_RXOVR_EN      8
`define CTL_PHASE_EN      9
`define CTL_RATE_EN       10
`define CTL_TXUND_EN      11
`define CTL_AUTO_RESET    12
`define CTL_RESET         13'h00F0

// ----------------------------------------
// Status fields (flags 5:0 are write-one-to-clear)
// ----------------------------------------
`define STA_RXOVR         0
`define STA_PHASE         1
`define STA_RATE          2
`define STA_TXUND         3
`define STA_RXIRQ         4
`define STA_TXIRQ         5
`define STA_TXFULL        8
`define STA_RXFULL        9
`define STA_BUSY          10

// ----------------------------------------
// General purpose port: latch 2:0, direction 6:4
// Bit 2 clock line, 1 master-out line, 0 master-in line
// ----------------------------------------
`define GP_LATCH_RESET    3'h7
`define GP_DIR_RESET      3'h0
`define BAUD_RESET        16'h0000

`endif

/* verilog/sync_serial_port_core.v */
// Chosen here: the Wishbone interface to the registers and the register offsets.
`include "ssc_map.vh"

module sync_serial_port_core (
    input  wire        sys_clk,
    input  wire        reset_n,
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [4:0]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    input  wire        clockLineIn,
    output reg         clockLineOut,
    output reg         clockLineOe,
    input  wire        masterOutSlaveInLineIn,
    output reg         masterOutSlaveInLineOut,
    output reg         masterOutSlaveInLineOe,
    input  wire        masterInSlaveOutLineIn,
    output reg         masterInSlaveOutLineOut,
    output reg         masterInSlaveOutLineOe,
    output reg         errorIrqRequest
);

    // ----------------------------------------
    // State
    // ----------------------------------------
    reg  [12:0] portControlWord;
    reg  [5:0]  flags;
    reg  [2:0]  gpPortLatch;
    reg  [2:0]  gpPortDirection;
    reg  [15:0] baudReload;
    reg  [15:0] baudCount;
    reg         prescale;
    reg  [15:0] txBuffer;
    reg         txFull;
    reg         txUpdated;
    reg  [15:0] rxBuffer;
    reg         rxFull;
    reg  [15:0] shiftReg;
    reg         outBit;
    reg         latchedBit;
    reg         active;
    reg  [4:0]  halfStep;
    reg         clockPrev;
    reg         dataPrev;
    reg  [3:0]  changeHist;
    reg  [1:0]  latchPipe;
    reg  [16:0] edgeGap;

    wire        portEnable = portControlWord[`CTL_PORT_ENABLE];
    wire        masterSelect = portControlWord[`CTL_MASTER];
    wire        clockPhaseSelect = portControlWord[`CTL_PHASE];
    wire        clockIdlePolarity = portControlWord[`CTL_POLARITY];
    wire [3:0]  widthM1 = portControlWord[`CTL_WIDTH_HI:`CTL_WIDTH_LO];
    wire        autoResetEnable = portControlWord[`CTL_AUTO_RESET];

    // ----------------------------------------
    // Bus decode
    // ----------------------------------------
    wire        busReq = wb_cyc_i & wb_stb_i;
    wire        busWrite = busReq & wb_we_i & wb_ack_o;
    wire        busRead = busReq & ~wb_we_i & wb_ack_o;
    wire        wrCtl = busWrite & (wb_adr_i == `OFS_CONTROL);
    wire        wrSta = busWrite & (wb_adr_i == `OFS_STATUS);
    wire        wrTx = busWrite & (wb_adr_i == `OFS_TX_BUFFER);
    wire        wrBaud = busWrite & (wb_adr_i == `OFS_BAUD);
    wire        wrGp = busWrite & (wb_adr_i == `OFS_GP_PORT);
    wire        rdRx = busRead & (wb_adr_i == `OFS_RX_BUFFER);
    wire [15:0] ctlMerged;

    function [15:0] laneMerge;
        input [15:0] old;
        input [31:0] data;
        input [3:0]  sel;
        begin
            laneMerge = {sel[1] ? data[15:8] : old[15:8], sel[0] ? data[7:0] : old[7:0]};
        end
    endfunction

    assign ctlMerged = laneMerge({3'h0, portControlWord}, wb_dat_i, wb_sel_i);

    // ----------------------------------------
    // Baud timing
    // ----------------------------------------
    // Position within one bit: two clock cycles per timer step
    wire [16:0] bitPos = {baudReload - baudCount, prescale};
    wire [16:0] halfLen = {1'b0, baudReload} + 17'h00001;
    wire        halfTick = portEnable & ((bitPos == 17'h00000) | (bitPos == halfLen));

    // ----------------------------------------
    // Shift events
    // ----------------------------------------
    wire        dataIn = masterSelect ? masterInSlaveOutLineIn : masterOutSlaveInLineIn;
    wire        clockEdge = clockLineIn != clockPrev;
    wire        slaveEv = portEnable & ~masterSelect & clockEdge;
    wire        ev = masterSelect ? (halfTick & active) : slaveEv;
    wire        leading = ~halfStep[0];
    wire [4:0]  nextStep = halfStep + 5'h01;
    wire [4:0]  lastStep = {widthM1, 1'b0} + 5'h02;
    wire        lastEv = ev & (nextStep == lastStep);
    wire        latchEv = ev & (leading ^ clockPhaseSelect);
    wire        shiftEv = ev & ~(leading ^ clockPhaseSelect) & (halfStep != 5'h00) & ~lastEv;
    wire        lastBit = latchEv ? dataIn : latchedBit;
    wire [15:0] wordMask = 16'hFFFF >> (4'hF - widthM1);
    wire [15:0] rxWord = {shiftReg[14:0], lastBit} & wordMask;
    wire [15:0] shiftNext = {shiftReg[14:0], latchedBit};
    wire        slaveStart = slaveEv & (halfStep == 5'h00);
    wire        loadIdle = portEnable & txFull & (halfStep == 5'h00) & ~active
                           & (masterSelect ? halfTick : ~clockEdge);

    // Slave clock rate check against own generator
    wire [16:0] gapNow = edgeGap + 17'h00001;
    wire        tooFast = gapNow < {1'b0, halfLen[16:1]};
    wire        tooSlow = gapNow > {halfLen[15:0], 1'b0};
    wire        rateFault = portEnable & ~masterSelect & (halfStep != 5'h00)
                            & ((slaveEv & tooFast) | tooSlow);
    wire        phaseFault = portEnable & latchPipe[1] & (|changeHist);
    wire        overrunEv = lastEv & rxFull;
    wire        underrunEv = slaveStart & ~txUpdated;
    wire        errEnabled = (overrunEv & portControlWord[`CTL_RXOVR_EN])
                             | (phaseFault & portControlWord[`CTL_PHASE_EN])
                             | (rateFault & portControlWord[`CTL_RATE_EN])
                             | (underrunEv & portControlWord[`CTL_TXUND_EN]);

    // Alternate outputs: high while unused so the latch owns the pin
    wire        clockAlt = (portEnable & masterSelect) ? (clockIdlePolarity ^ (active & halfStep[0])) : 1'b1;
    wire        mosiAlt = (portEnable & masterSelect) ? outBit : 1'b1;
    wire        misoAlt = (portEnable & ~masterSelect) ? outBit : 1'b1;

    reg  [31:0] readData;
    always @* begin
        if (wb_adr_i == `OFS_CONTROL) begin
            readData = {19'h00000, portControlWord};
        end else if (wb_adr_i == `OFS_STATUS) begin
            readData = {21'h000000, active | (halfStep != 5'h00), rxFull, txFull, 2'h0, flags};
        end else if (wb_adr_i == `OFS_TX_BUFFER) begin
            readData = {16'h0000, txBuffer};
        end else if (wb_adr_i == `OFS_RX_BUFFER) begin
            readData = {16'h0000, rxBuffer};
        end else if (wb_adr_i == `OFS_BAUD) begin
            readData = {16'h0000, portEnable ? baudCount : baudReload};
        end else if (wb_adr_i == `OFS_GP_PORT) begin
            readData = {25'h0000000, gpPortDirection, 1'b0, gpPortLatch};
        end else begin
            readData = 32'h00000000;
        end
    end

    // ----------------------------------------
    // Bus slave
    // ----------------------------------------
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= busReq & ~wb_ack_o;
            if (busReq & ~wb_ack_o) begin
                wb_dat_o <= readData;
            end
        end
    end

    // ----------------------------------------
    // Configuration, timer and pins
    // ----------------------------------------
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            portControlWord <= `CTL_RESET;
            gpPortLatch <= `GP_LATCH_RESET;
            gpPortDirection <= `GP_DIR_RESET;
            baudReload <= `BAUD_RESET;
            baudCount <= `BAUD_RESET;
            prescale <= 1'b0;
            clockLineOut <= 1'b1;
            clockLineOe <= 1'b0;
            masterOutSlaveInLineOut <= 1'b1;
            masterOutSlaveInLineOe <= 1'b0;
            masterInSlaveOutLineOut <= 1'b1;
            masterInSlaveOutLineOe <= 1'b0;
            errorIrqRequest <= 1'b0;
        end else begin
            if (wrCtl) begin
                // Width only changes while disabled
                if (!portEnable) begin
                    portControlWord <= ctlMerged[12:0];
                end else begin
                    portControlWord <= {ctlMerged[12:8], widthM1, ctlMerged[3:0]};
                end
            end
            if (wrGp & wb_sel_i[0]) begin
                gpPortLatch <= wb_dat_i[2:0];
                gpPortDirection <= wb_dat_i[6:4];
            end
            if (wrBaud & !portEnable) begin
                baudReload <= laneMerge(baudReload, wb_dat_i, wb_sel_i);
            end
            if (!portEnable) begin
                baudCount <= baudReload;
                prescale <= 1'b0;
            end else begin
                prescale <= ~prescale;
                if (prescale) begin
                    baudCount <= (baudCount == 16'h0000) ? baudReload : baudCount - 16'h0001;
                end
            end
            clockLineOut <= gpPortLatch[2] & clockAlt;
            masterOutSlaveInLineOut <= gpPortLatch[1] & mosiAlt;
            masterInSlaveOutLineOut <= gpPortLatch[0] & misoAlt;
            clockLineOe <= gpPortDirection[2];
            masterOutSlaveInLineOe <= gpPortDirection[1];
            masterInSlaveOutLineOe <= gpPortDirection[0];
            errorIrqRequest <= errEnabled;
        end
    end

    // ----------------------------------------
    // Shift engine and flags
    // ----------------------------------------
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            flags <= 6'h00;
            txBuffer <= 16'h0000;
            txFull <= 1'b0;
            txUpdated <= 1'b0;
            rxBuffer <= 16'h0000;
            rxFull <= 1'b0;
            shiftReg <= 16'h0000;
            outBit <= 1'b1;
            latchedBit <= 1'b0;
            active <= 1'b0;
            halfStep <= 5'h00;
            clockPrev <= 1'b0;
            dataPrev <= 1'b0;
            changeHist <= 4'h0;
            latchPipe <= 2'h0;
            edgeGap <= 17'h00000;
        end else begin
            clockPrev <= clockLineIn;
            dataPrev <= dataIn;
            changeHist <= {changeHist[2:0], dataIn != dataPrev};
            latchPipe <= {latchPipe[0], latchEv};
            if (slaveEv | (halfStep == 5'h00)) begin
                edgeGap <= 17'h00000;
            end else if (edgeGap != 17'h1FFFF) begin
                edgeGap <= gapNow;
            end
            if (wrSta & wb_sel_i[0]) begin
                flags <= flags & ~wb_dat_i[5:0];
            end
            if (rdRx) begin
                rxFull <= 1'b0;
            end
            if (wrTx) begin
                txBuffer <= laneMerge(txBuffer, wb_dat_i, wb_sel_i);
                txFull <= 1'b1;
                txUpdated <= 1'b1;
            end
            if (!portEnable) begin
                active <= 1'b0;
                halfStep <= 5'h00;
            end else if (rateFault & autoResetEnable) begin
                active <= 1'b0;
                halfStep <= 5'h00;
            end else if (ev) begin
                if (slaveStart) begin
                    active <= 1'b1;
                    txUpdated <= wrTx;
                end
                if (latchEv) begin
                    latchedBit <= dataIn;
                end
                if (shiftEv) begin
                    shiftReg <= shiftNext;
                    outBit <= shiftNext[widthM1];
                end
                if (lastEv) begin
                    rxBuffer <= rxWord;
                    rxFull <= 1'b1;
                    if (txFull & ~wrTx) begin
                        shiftReg <= txBuffer;
                        outBit <= txBuffer[widthM1];
                        txFull <= 1'b0;
                        halfStep <= 5'h00;
                        // A master frame is a transfer too: later slave start needs a fresh write
                        if (masterSelect) begin
                            txUpdated <= 1'b0;
                        end
                    end else begin
                        active <= 1'b0;
                        halfStep <= 5'h00;
                    end
                end else begin
                    halfStep <= nextStep;
                end
            end else if (loadIdle & ~wrTx) begin
                shiftReg <= txBuffer;
                outBit <= txBuffer[widthM1];
                txFull <= 1'b0;
                active <= masterSelect;
                if (masterSelect) begin
                    txUpdated <= 1'b0;
                end
            end
            // Hardware events set after software clears, so a set always wins
            if (overrunEv) begin
                flags[`STA_RXOVR] <= 1'b1;
            end
            if (phaseFault) begin
                flags[`STA_PHASE] <= 1'b1;
            end
            if (rateFault) begin
                flags[`STA_RATE] <= 1'b1;
            end
            if (underrunEv) begin
                flags[`STA_TXUND] <= 1'b1;
            end
            if (lastEv) begin
                flags[`STA_RXIRQ] <= 1'b1;
            end
            if ((lastEv | loadIdle) & txFull & ~wrTx & portEnable & ~(rateFault & autoResetEnable)) begin
                flags[`STA_TXIRQ] <= 1'b1;
            end
        end
    end

endmodule // sync_serial_port_core

/* dv/sync_serial_port_props.sv */
`include "ssc_map.vh"

module sync_serial_port_props (
    input logic        sys_clk,
    input logic        reset_n,
    input logic        wb_cyc_i,
    input logic        wb_stb_i,
    input logic        wb_we_i,
    input logic [4:0]  wb_adr_i,
    input logic [3:0]  wb_sel_i,
    input logic [31:0] wb_dat_i,
    input logic [31:0] wb_dat_o,
    input logic        wb_ack_o,
    input logic        clockLineOut,
    input logic        clockLineOe,
    input logic        masterOutSlaveInLineOut,
    input logic        masterOutSlaveInLineOe,
    input logic        masterInSlaveOutLineOut,
    input logic        masterInSlaveOutLineOe
);
    logic        en, ms, pol, enD, msD, polD;
    logic [2:0]  lat, latD, dir, dirD;
    logic [15:0] baud;
    int          hiCnt;
    wire         wrOk = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0];
    // ----------------------------------------
    // Shadow copies, delayed once more because the pins are registered
    // ----------------------------------------
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            {en, ms, pol, enD, msD, polD} <= '0;
            {lat, latD} <= {`GP_LATCH_RESET, `GP_LATCH_RESET};
            {dir, dirD} <= {`GP_DIR_RESET, `GP_DIR_RESET};
            baud <= `BAUD_RESET;
            hiCnt <= 0;
        end else begin
            if (wrOk && wb_adr_i == `OFS_CONTROL) {pol, ms, en} <= {wb_dat_i[3], wb_dat_i[1:0]};
            if (wrOk && wb_adr_i == `OFS_GP_PORT) {dir, lat} <= {wb_dat_i[6:4], wb_dat_i[2:0]};
            if (wrOk && wb_adr_i == `OFS_BAUD && !en) baud <= wb_dat_i[15:0];
            {enD, msD, polD, latD, dirD} <= {en, ms, pol, lat, dir};
            hiCnt <= clockLineOut ? hiCnt + 1 : 0;
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    property p_ack_gap; wb_ack_o |=> !wb_ack_o; endproperty
    a_ack_gap: assert property (p_ack_gap) else $error("ack longer than one cycle");
    property p_ack_due; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
    a_ack_due: assert property (p_ack_due) else $error("ack late");
    property p_ack_idle; !wb_stb_i |=> !wb_ack_o; endproperty
    a_ack_idle: assert property (p_ack_idle) else $error("ack without request");
    property p_hole; wb_ack_o && !wb_we_i && wb_adr_i > `OFS_GP_PORT |-> wb_dat_o == 32'h0; endproperty
    a_hole: assert property (p_hole) else $error("unmapped read not zero");
    property p_clk_gate; !enD || !msD |-> clockLineOut == latD[2]; endproperty
    a_clk_gate: assert property (p_clk_gate) else $error("clock pin not latch");
    property p_mosi_gate; !enD || !msD |-> masterOutSlaveInLineOut == latD[1]; endproperty
    a_mosi_gate: assert property (p_mosi_gate) else $error("out line not latch");
    property p_miso_gate; !enD || msD |-> masterInSlaveOutLineOut == latD[0]; endproperty
    a_miso_gate: assert property (p_miso_gate) else $error("in line not latch");
    property p_dir; {clockLineOe, masterOutSlaveInLineOe, masterInSlaveOutLineOe} == dirD; endproperty
    a_dir: assert property (p_dir) else $error("pin enable not direction");
    property p_half;
        $past(enD) && enD && msD && !polD && latD[2] && $fell(clockLineOut) |-> hiCnt == baud + 1;
    endproperty
    a_half: assert property (p_half) else $error("half bit time wrong");
    c_write: cover property (wb_ack_o && wb_we_i);
    c_master: cover property (enD && msD && $fell(clockLineOut));
    c_slave: cover property (enD && !msD && !masterInSlaveOutLineOut);
endmodule // sync_serial_port_props

/* dv/serial_peer.sv */
module serial_peer (
    input  logic sys_clk,
    input  logic clkLine,
    input  logic mosiLine,
    input  logic misoLine,
    output logic pClk,
    output logic pClkOe,
    output logic pMosi,
    output logic pMosiOe,
    output logic pMiso,
    output logic pMisoOe
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] txSh, rxSh, mGot;
    logic        armed, seen, prevClk;
    int          gap, maxGap;
    initial begin
        {pClk, pClkOe, pMosi, pMosiOe, armed, seen, prevClk} = '0;
        {txSh, rxSh, mGot} = {16'hFFFF, 16'h0000, 16'h0000};
        {gap, maxGap} = {0, 0};
    end
    assign pMiso   = txSh[15];
    assign pMisoOe = armed;
    // ----------------------------------------
    // Slave role: latch on rising, shift on falling
    // ----------------------------------------
    always @(posedge sys_clk) begin
        prevClk <= clkLine;
        gap <= gap + 1;
        if (clkLine && !prevClk) begin
            rxSh <= {rxSh[14:0], mosiLine};
            gap <= 0;
            seen <= 1'b1;
            if (seen && gap + 1 > maxGap) maxGap <= gap + 1;
        end
        if (!clkLine && prevClk && armed) txSh <= {txSh[14:0], 1'b1};
    end
    task automatic load(input logic [15:0] w);
        {txSh, rxSh, armed, seen, maxGap} = {w, 16'h0000, 1'b1, 1'b0, 0};
    endtask
    // Clock must sit at idle before the far end is enabled
    task automatic grab();
        @(posedge sys_clk);
        {armed, pClk, pClkOe} <= 3'b001;
    endtask
    task automatic xfer(input logic [15:0] w, input int n, input int half);
        @(posedge sys_clk);
        pMosiOe <= 1'b1;
        pMosi <= w[n-1];
        for (int i = n - 1; i >= 0; i--) begin
            repeat (half) @(posedge sys_clk);
            pClk <= 1'b1;
            mGot <= {mGot[14:0], misoLine};
            repeat (half) @(posedge sys_clk);
            pClk <= 1'b0;
            if (i > 0) pMosi <= w[i-1];
        end
        repeat (half) @(posedge sys_clk);
        pMosiOe <= 1'b0;
    endtask
endmodule // serial_peer

/* dv/sync_serial_port_core_bench.sv */
`include "ssc_map.vh"

module sync_serial_port_core_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic        sys_clk = 1'b0, reset_n = 1'b0, irqSeen = 1'b0;
    logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [4:0]  wb_adr_i = 5'h00;
    logic [3:0]  wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
    logic        wb_ack_o, clockLineOut, clockLineOe, masterOutSlaveInLineOut, masterOutSlaveInLineOe;
    logic        masterInSlaveOutLineOut, masterInSlaveOutLineOe, errorIrqRequest;
    logic        pClk, pClkOe, pMosi, pMosiOe, pMiso, pMisoOe;
    int          err_total = 0, cmp_count = 0;
    // Pulled-up shared lines
    wire         clkW  = (clockLineOe ? clockLineOut : 1'b1) & (pClkOe ? pClk : 1'b1);
    wire         mosiW = (masterOutSlaveInLineOe ? masterOutSlaveInLineOut : 1'b1) & (pMosiOe ? pMosi : 1'b1);
    wire         misoW = (masterInSlaveOutLineOe ? masterInSlaveOutLineOut : 1'b1) & (pMisoOe ? pMiso : 1'b1);
    always #5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) if (errorIrqRequest === 1'b1) irqSeen <= 1'b1;
    sync_serial_port_core i_sync_serial_port_core (
        .sys_clk, .reset_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
        .wb_ack_o, .clockLineIn(clkW), .clockLineOut, .clockLineOe, .masterOutSlaveInLineIn(mosiW),
        .masterOutSlaveInLineOut, .masterOutSlaveInLineOe, .masterInSlaveOutLineIn(misoW),
        .masterInSlaveOutLineOut, .masterInSlaveOutLineOe, .errorIrqRequest);
    serial_peer i_serial_peer (.sys_clk, .clkLine(clkW), .mosiLine(mosiW), .misoLine(misoW),
        .pClk, .pClkOe, .pMosi, .pMosiOe, .pMiso, .pMisoOe);
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic conclude();
        if (err_total == 0 && cmp_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("FAIL %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wb(input logic we, input logic [4:0] a, input logic [15:0] d);
        int n;
        n = 0;
        @(posedge sys_clk);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} <= {2'b11, we, a, 4'h3, 16'h0, d};
        do begin
            @(posedge sys_clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        q = wb_dat_o;
        {wb_cyc_i, wb_stb_i} <= 2'b00;
        chk("ack", wb_ack_o, 1'b1);
        if (wb_ack_o !== 1'b1) conclude();
    endtask
    task automatic wait_sta(input int b, input logic v);
        int n;
        n = 0;
        do begin
            wb(1'b0, `OFS_STATUS, 16'h0000);
            n++;
        end while (q[b] !== v && n < 100);
        chk("status bit", q[b], v);
        if (q[b] !== v) conclude();
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic s_reset();
        chk("pins", {clockLineOut, masterOutSlaveInLineOut, masterInSlaveOutLineOut, clockLineOe,
            masterOutSlaveInLineOe, masterInSlaveOutLineOe}, 32'h0000_0038);
        wb(1'b0, `OFS_CONTROL, 16'h0000);
        chk("control", q, {19'h0, `CTL_RESET});
        wb(1'b0, `OFS_GP_PORT, 16'h0000);
        chk("gp port", q, 32'h0000_0007);
        wb(1'b1, 5'h18, 16'hFFFF);
        wb(1'b0, 5'h18, 16'h0000);
        chk("hole", q, 32'h0000_0000);
        wb(1'b1, `OFS_BAUD, 16'hFFFF);
        wb(1'b0, `OFS_BAUD, 16'h0000);
        chk("reload max", q, 32'h0000_FFFF);
    endtask
    task automatic s_master();
        wb(1'b1, `OFS_BAUD, 16'h0002);
        wb(1'b1, `OFS_GP_PORT, 16'h0067);
        wb(1'b1, `OFS_CONTROL, 16'h0173);
        wb(1'b1, `OFS_BAUD, 16'h0005);
        wb(1'b0, `OFS_BAUD, 16'h0000);
        chk("live count", q <= 32'h0000_0002, 1'b1);
        i_serial_peer.load(16'h3CC3);
        irqSeen <= 1'b0;
        wb(1'b1, `OFS_TX_BUFFER, 16'h00A5);
        wait_sta(`STA_TXIRQ, 1'b1);
        wb(1'b1, `OFS_TX_BUFFER, 16'h005A);
        wait_sta(`STA_BUSY, 1'b0);
        chk("peer word", i_serial_peer.rxSh, 16'hA55A);
        chk("bit time", i_serial_peer.maxGap, 32'h0000_0006);
        wb(1'b0, `OFS_STATUS, 16'h0000);
        chk("rx flags", {q[`STA_RXIRQ], q[`STA_RXOVR]}, 2'b11);
        chk("err irq", irqSeen, 1'b1);
        wb(1'b0, `OFS_RX_BUFFER, 16'h0000);
        chk("rx word", q, 32'h0000_00C3);
        wb(1'b1, `OFS_STATUS, 16'h003F);
        wb(1'b0, `OFS_STATUS, 16'h0000);
        chk("cleared", q[5:0], 6'h00);
    endtask
    task automatic s_slave();
        int n;
        wb(1'b1, `OFS_CONTROL, 16'h0070);
        wb(1'b0, `OFS_BAUD, 16'h0000);
        chk("reload kept", q, 32'h0000_0002);
        i_serial_peer.grab();
        wb(1'b1, `OFS_GP_PORT, 16'h0017);
        irqSeen <= 1'b0;
        wb(1'b1, `OFS_CONTROL, 16'h0871);
        i_serial_peer.xfer(16'h0096, 8, 3);
        wb(1'b0, `OFS_STATUS, 16'h0000);
        chk("underrun", q[`STA_TXUND], 1'b1);
        chk("err irq", irqSeen, 1'b1);
        wb(1'b0, `OFS_RX_BUFFER, 16'h0000);
        chk("slave rx", q, 32'h0000_0096);
        wb(1'b1, `OFS_STATUS, 16'h003F);
        wb(1'b1, `OFS_TX_BUFFER, 16'h004B);
        n = 0;
        while (misoW !== 1'b0 && n < 4) begin
            @(posedge sys_clk);
            n++;
        end
        chk("first bit", misoW, 1'b0);
        i_serial_peer.xfer(16'h0069, 8, 3);
        chk("slave out", i_serial_peer.mGot[7:0], 8'h4B);
        wb(1'b0, `OFS_STATUS, 16'h0000);
        chk("no underrun", q[`STA_TXUND], 1'b0);
        wb(1'b0, `OFS_RX_BUFFER, 16'h0000);
        chk("slave rx2", q, 32'h0000_0069);
    endtask
    initial begin
        repeat (8) @(posedge sys_clk);
        reset_n <= 1'b1;
        s_reset();
        s_master();
        s_slave();
        conclude();
    end
endmodule // sync_serial_port_core_bench

bind sync_serial_port_core sync_serial_port_props i_sync_serial_port_props (
    .sys_clk, .reset_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
    .wb_ack_o, .clockLineOut, .clockLineOe, .masterOutSlaveInLineOut, .masterOutSlaveInLineOe,
    .masterInSlaveOutLineOut, .masterInSlaveOutLineOe);
